/* hw/pic_defs.vh */
// Constants for the parallel-port interrupt configuration block.
// Included by the design files by bare name.
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH
`define PIC_ADDR_CFG_LOW   32'h800000A8
`define PIC_ADDR_CFG_HIGH  32'h800000AC
`define PIC_ADDR_MATCH_W   8
`define PIC_SEL_LSB        0
`define PIC_SEL_MSB        4
`define PIC_POL_BIT        5
`define PIC_EDGE_BIT       6
`define PIC_EN_BIT         7
`define PIC_LANE_W         8
`define PIC_CFG_RESET      32'h00000000
`define PIC_EN_MASK        32'h80808080
`define PIC_PORT_DATA_LO   16
`endif

/* hw/pic_channel.v */
// One interrupt channel: line select, polarity, level or edge detection, enable.
// Assumes port lines synchronous to i_clock.
`timescale 1ns/1ps
`include "pic_defs.vh"
module pic_channel
(
  input  wire        i_clock,
  input  wire        i_rst_n,
  input  wire [7:0]  i_cfg,
  input  wire [31:0] i_port,
  output reg         o_irq
);
  wire [4:0] port_select;
  wire       polarity;
  wire       edge_mode;
  wire       enable;
  wire       line;
  wire       active;
  reg        prev_active;
  wire       next_irq;

  assign port_select = i_cfg[`PIC_SEL_MSB:`PIC_SEL_LSB];   // RL4
  assign polarity    = i_cfg[`PIC_POL_BIT];
  assign edge_mode   = i_cfg[`PIC_EDGE_BIT];
  assign enable      = i_cfg[`PIC_EN_BIT];
  assign line        = i_port[port_select];                // RL4
  assign active      = polarity ? line : ~line;            // RL3
  // Edge mode gives a one-cycle pulse on the chosen transition
  assign next_irq    = enable & (edge_mode ? (active & ~prev_active) : active); // RL1 RL2

  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      prev_active <= 1'b0;
      o_irq       <= 1'b0;
    end
    else
    begin
      prev_active <= active;
      o_irq       <= next_irq;
    end
  end
endmodule

/* hw/pic_top.v */
// Parallel-port interrupt configuration: two APB registers, eight channels.
// Assumes APB master with 32-bit data and port lines synchronous to i_clock.
//
// Function
// RL1: A channel raises its interrupt only while its enable bit is one.
// RL2: Trigger-mode bit one detects edges, zero follows the line level.
// RL3: Polarity one means high level or rising edge, zero low or falling.
// RL4: Five-bit selector picks one of port lines 0 to 31 per channel.
// RL5: Eight channels; channels 4 to 7 live in a second register.
// RL6: Lowest lane: selector bits 4:0, polarity 5, mode 6, enable 7.
// RL7: Second lane: selector bits 12:8, polarity 13, mode 14, enable 15.
// RL8: Third lane: selector bits 20:16, polarity 21, mode 22, enable 23.
// RL9: Lines 16 to 31 are data bus bytes, usable only in 8-bit mode.
// RL10: Reset clears all enable bits so every channel starts masked.
`timescale 1ns/1ps
`include "pic_defs.vh"
module pic_top
#(
  parameter NUM_CHANNELS = 8
)
(
  input  wire        i_clock,
  input  wire        i_rst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [31:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire [31:0] i_port,
  input  wire        i_bus_8bit_mode,
  output wire [7:0]  o_irq
);
  reg  [31:0] cfg_low;
  reg  [31:0] cfg_high;
  wire [31:0] port_eff;
  wire        hit_low;
  wire        hit_high;
  wire        access;
  wire [63:0] cfg_all;
  wire        hit_low_full;

  // Full-width decode; a partial match would alias other registers
  assign hit_low  = i_paddr == `PIC_ADDR_CFG_LOW;
  assign hit_low_full = hit_low;
  assign hit_high = i_paddr == `PIC_ADDR_CFG_HIGH;          // RL5
  assign access   = i_psel & i_penable & ~o_pready;
  assign cfg_all  = {cfg_high, cfg_low};

  // Upper lines only count when the memory bus frees them
  assign port_eff = {i_port[31:`PIC_PORT_DATA_LO] & {16{i_bus_8bit_mode}},
                     i_port[`PIC_PORT_DATA_LO-1:0]};       // RL9

  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      // Other fields are undefined after reset; zero is simplest
      cfg_low   <= `PIC_CFG_RESET & ~`PIC_EN_MASK;         // RL10
      cfg_high  <= `PIC_CFG_RESET & ~`PIC_EN_MASK;         // RL10
      o_prdata  <= 32'h00000000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= access;
      o_pslverr <= access & ~(hit_low_full | hit_high);
      o_prdata  <= 32'h00000000;
      if (access & i_pwrite & hit_low_full)
      begin
        cfg_low <= i_pwdata;                               // RL6 RL7 RL8
      end
      if (access & i_pwrite & hit_high)
      begin
        cfg_high <= i_pwdata;                              // RL5 RL6 RL7 RL8
      end
      if (access & ~i_pwrite)
      begin
        if (hit_low_full)
        begin
          o_prdata <= cfg_low;
        end
        else if (hit_high)
        begin
          o_prdata <= cfg_high;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g = g + 1)
    begin : gen_ch
      pic_channel u_ch
      (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_cfg   (cfg_all[g*`PIC_LANE_W +: `PIC_LANE_W]),  // RL6 RL7 RL8
        .i_port  (port_eff),
        .o_irq   (o_irq[g])
      );
    end
  endgenerate
endmodule

/* testbench/pic_pins.sv */
// Port-line model for pic_top.
// Assumes lines are set after an edge.
`timescale 1ns/1ps
module pic_pins (input wire [31:0] i_lv, output wire [31:0] o_port);
  assign o_port = i_lv;
endmodule

/* testbench/pic_chk_checker.sv */
// Port checker for pic_top.
// Assumes it is bound to pic_top.
`timescale 1ns/1ps
module pic_chk (input wire i_clock, i_rst_n, i_psel, i_penable, i_pwrite, o_pready,
  o_pslverr, input wire [31:0] i_paddr, o_prdata, input wire [7:0] o_irq);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  reg w;
  wire t = i_psel && i_penable && !o_pready;
  wire m = i_paddr == 32'h800000A8 || i_paddr == 32'h800000AC;
  // No mapped write yet: every channel still masked
  always @(posedge i_clock)
    w <= i_rst_n && (w || t && i_pwrite && m);
  property p_rdy; t |=> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("rdy");
  property p_one; o_pready |=> !o_pready; endproperty
  a_one: assert property (p_one) else $error("one");
  property p_err; o_pready |-> o_pslverr == !m; endproperty
  a_err: assert property (p_err) else $error("err");
  property p_bad; o_pready && !m |-> o_prdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("bad");
  property p_sle; !o_pready |-> !o_pslverr; endproperty
  a_sle: assert property (p_sle) else $error("sle");
  property p_idl; !i_psel |=> !o_pready; endproperty
  a_idl: assert property (p_idl) else $error("idl");
  property p_rst; $rose(i_rst_n) |-> o_irq == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_msk; !w |-> o_irq == 8'h00; endproperty
  a_msk: assert property (p_msk) else $error("msk");
endmodule
bind pic_top pic_chk pic_chk_i (.*);

/* testbench/tb_top.sv */
// Bench for pic_top: APB access and port lines.
// Assumes the bound checker and pin model.
`timescale 1ns/1ps
module tb_top;
  logic i_clock = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic o_pready, o_pslverr, i_bus_8bit_mode = 1;
  logic [31:0] i_paddr = 0, i_pwdata = 0, o_prdata, i_port, lv = 0;
  logic [7:0] o_irq;
  int num_errors = 0, comparisons = 0;
  always #2.5 i_clock = ~i_clock;
  pic_top pic_top_i (.*);
  pic_pins pic_pins_i (.i_lv(lv), .o_port(i_port));
  task chk(string n, logic [31:0] x, g);
    comparisons++;
    num_errors += g !== x;
    if (g !== x) $display("CHECK FAILED %s exp %h got %h", n, x, g);
  endtask
  task bus(logic w, logic [31:0] a, d, logic e);
    @(posedge i_clock);
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
    @(posedge i_clock);
    i_penable <= 1;
    do @(posedge i_clock); while (o_pready !== 1);
    {i_psel, i_penable} <= 2'b0;
    if (!w) chk("rdata", d, o_prdata);
    chk("slverr", e, o_pslverr);
  endtask
  task pt(logic [31:0] p, logic [7:0] x, y);
    @(posedge i_clock);
    lv <= p;
    @(posedge i_clock);
    #1 chk("irq", x, o_irq);
    @(posedge i_clock);
    #1 chk("irq", y, o_irq);
  endtask
  task summarize;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #20000 num_errors++;
    summarize;
  end
  initial
  begin
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1;
    bus(0, 32'h800000A8, 0, 0);
    bus(0, 32'h800000A4, 0, 1);
    bus(1, 32'h800000A8, 32'hBF90A883, 0);
    bus(0, 32'h800000A8, 32'hBF90A883, 0);
    bus(1, 32'h800000AC, 32'hB80CB180, 0);
    $display("regs done");
    pt(0, 8'h15, 8'h15);
    pt(32'h00020008, 8'h34, 8'h34);
    @(posedge i_clock) i_bus_8bit_mode <= 0;
    pt('1, 8'h06, 8'h06);
    @(posedge i_clock) i_bus_8bit_mode <= 1;
    bus(1, 32'h800000A8, 32'hFFD0E8C3, 0);
    bus(1, 32'h800000AC, 32'hF84CF1C0, 0);
    pt(0, 8'h15, 8'h00);
    bus(1, 32'h800000A8, 32'h7F506843, 0);
    pt('1, 8'hA0, 8'h00);
    $display("irq done");
    summarize;
  end
endmodule
